// [src/supervisor_pkg.sv]
// Package of constants, pin carrier and state codes for the supervisor.
`default_nettype none
package supervisor_pkg;

	////////////////////////////////////////////////////////////////////////
	// APB register map: byte addresses, one aligned word each.
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_CTRL = 12'h004;
	localparam logic [11:0] ADDR_TIMER = 12'h008;

	// Control register: bit 0 lets software enable the watchdog.
	localparam int CTRL_WD_EN_BIT = 0;
	localparam logic CTRL_WD_EN_RESET = 1'b1;

	// Status register field positions.
	localparam int ST_BELOW_THR_BIT = 0;
	localparam int ST_BELOW_BAK_BIT = 1;
	localparam int ST_SENSE_LOW_BIT = 2;
	localparam int ST_BATT_BIT = 3;
	localparam int ST_RESET_BIT = 4;
	localparam int ST_TIMEOUT_BIT = 5;
	localparam int ST_FIRST_BIT = 6;
	localparam int ST_WD_ON_BIT = 7;
	localparam int ST_EXT_BIT = 8;
	localparam int ST_STATE_LSB = 9;

	////////////////////////////////////////////////////////////////////////
	// Timing: clock rate, internal tick and period lengths.
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int RESET_MS = 200;
	localparam int WD_SHORT_MS = 100;
	localparam int WD_LONG_MS = 1600;
	localparam logic [11:0] RESET_TICKS = 12'(RESET_MS * 1000000 / TICK_NS);
	localparam logic [11:0] WD_SHORT_TICKS = 12'(WD_SHORT_MS * 1000000 / TICK_NS);
	localparam logic [11:0] WD_LONG_TICKS = 12'(WD_LONG_MS * 1000000 / TICK_NS);
	localparam logic [11:0] EXT_WD_PERIODS = 12'd1024;
	localparam logic [11:0] EXT_RESET_PERIODS = 12'd2048;
	localparam int CE_HOLD_NS = 15000;
	localparam logic [10:0] CE_HOLD_CYCLES = 11'(CE_HOLD_NS / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////
	// Comparator results and pin levels as they arrive at the logic.
	typedef struct packed {
		logic below_threshold;
		logic below_backup;
		logic sense_below_ref;
		logic kick_high;
		logic kick_low;
		logic timebase_select;
		logic timebase_level;
		logic chip_enable_in;
	} pins_t;

	// Reset and watchdog sequencing states.
	typedef enum logic [1:0] {
		ST_LOWV = 2'b00,
		ST_HOLD = 2'b01,
		ST_RUN = 2'b10
	} state_t;

endpackage : supervisor_pkg
`default_nettype wire

// [src/supply_supervisor_watchdog.sv]
// Supply supervisor with watchdog, chip-enable gate and APB registers.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor_watchdog #(
	parameter int TICK_LEN = supervisor_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire supervisor_pkg::pins_t pins,
	output logic reset_n,
	output logic reset_hi,
	output logic supply_low_flag,
	output logic powerfail_flag,
	output logic battery_active,
	output logic timeout_flag,
	output logic chip_enable_gated
);
	import supervisor_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations.
	pins_t meta_q;
	pins_t sync_q;
	pins_t prev_q;
	logic [31:0] div_q;
	state_t state_q;
	state_t state_d;
	logic [11:0] tmr_q;
	logic [11:0] tmr_d;
	logic rst_n_d;
	logic wdo_d;
	logic first_q;
	logic first_d;
	logic backup_q;
	logic [10:0] ce_tmr_q;
	logic [10:0] ce_tmr_d;
	logic ctrl_wd_en_q;
	logic [31:0] rdata;
	// Synchroniser reset values match the idle pin levels: supply good,
	// internal timebase on the long period, chip enable high and the kick
	// input floating, so no false edge or gate glitch follows a reset.
	localparam pins_t PINS_IDLE = 8'h07;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; levels are read from the second stage only.
	// The third stage keeps last cycle's level for the edge detectors.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= PINS_IDLE;
			sync_q <= PINS_IDLE;
			prev_q <= PINS_IDLE;
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Decoded pin levels and their edges.
	// A kick edge is a direct change between high and low; a pass through
	// the mid level is no edge; floating the pin instead holds the timer at zero.
	wire below = sync_q.below_threshold;
	wire below_rise = below & ~prev_q.below_threshold;
	wire ce_in = sync_q.chip_enable_in;
	wire ext_mode = ~sync_q.timebase_select;
	wire tb_rise = sync_q.timebase_level & ~prev_q.timebase_level;
	wire kick_valid = sync_q.kick_high | sync_q.kick_low;
	wire kick_edge = (sync_q.kick_high & prev_q.kick_low) |
		(sync_q.kick_low & prev_q.kick_high);
	wire wd_on = ctrl_wd_en_q & kick_valid;

	////////////////////////////////////////////////////////////////////////
	// Internal timebase divider producing a one-cycle millisecond tick.
	// It runs free, so the first tick of a period can come early by up to
	// one tick; every period is therefore exact to within one tick.
	wire div_tick = (div_q == 32'(TICK_LEN - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
		end else if (div_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 32'd1;
		end
	end

	// Tick source and period lengths for the selected timebase.
	// The short period is refused until the first kick after reset clears
	// the first-timeout flag, which gives the host time to take control.
	wire tick = ext_mode ? tb_rise : div_tick;
	wire [11:0] reset_len = ext_mode ? EXT_RESET_PERIODS : RESET_TICKS;
	wire use_long = first_q | sync_q.timebase_level;
	wire [11:0] int_wd_len = use_long ? WD_LONG_TICKS : WD_SHORT_TICKS;
	wire [11:0] wd_len = ext_mode ? EXT_WD_PERIODS : int_wd_len;
	wire hold_done = (tmr_q == reset_len - 12'd1);
	wire wd_expire = (tmr_q == wd_len - 12'd1);

	////////////////////////////////////////////////////////////////////////
	// Reset and watchdog sequencer; low supply overrides every state.
	// Low supply is applied last so that it wins over a timeout in the same
	// cycle. A kick edge outranks an expiry in the running state, so the
	// flag can never be set and cleared by one edge.
	always_comb begin
		state_d = state_q;
		tmr_d = tmr_q;
		rst_n_d = reset_n;
		wdo_d = timeout_flag;
		first_d = first_q;
		case (state_q)
			ST_LOWV: begin
				rst_n_d = 1'b0;
				tmr_d = '0;
				first_d = 1'b1;
				state_d = ST_HOLD;
			end
			ST_HOLD: begin
				rst_n_d = 1'b0;
				first_d = 1'b1;
				if (tick) begin
					if (hold_done) begin
						state_d = ST_RUN;
						tmr_d = '0;
						rst_n_d = 1'b1;
					end else begin
						tmr_d = tmr_q + 12'd1;
					end
				end
			end
			ST_RUN: begin
				rst_n_d = 1'b1;
				if (kick_edge) begin
					tmr_d = '0;
					first_d = 1'b0;
				end else if (!wd_on) begin
					tmr_d = '0;
				end else if (tick) begin
					if (wd_expire) begin
						wdo_d = 1'b0;
						rst_n_d = 1'b0;
						tmr_d = '0;
						state_d = ST_HOLD;
					end else begin
						tmr_d = tmr_q + 12'd1;
					end
				end
			end
			default: begin
				state_d = ST_LOWV;
				rst_n_d = 1'b0;
				tmr_d = '0;
			end
		endcase
		if (kick_edge) begin
			wdo_d = 1'b1;
		end
		if (!wd_on) begin
			wdo_d = 1'b1;
		end
		if (below) begin
			state_d = ST_LOWV;
			tmr_d = '0;
			rst_n_d = 1'b0;
			wdo_d = 1'b1;
			first_d = 1'b1;
		end
	end

	// Sequencer registers; both reset outputs share one next value.
	// Loading both from one value keeps them complementary on every cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_LOWV;
			tmr_q <= '0;
			reset_n <= 1'b0;
			reset_hi <= 1'b1;
			timeout_flag <= 1'b1;
			first_q <= 1'b1;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			reset_n <= rst_n_d;
			reset_hi <= ~rst_n_d;
			timeout_flag <= wdo_d;
			first_q <= first_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Supply switch: change over only when both comparisons agree.
	// When the comparisons disagree the switch keeps its last choice, which
	// avoids chatter between the two sources near the threshold.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			backup_q <= 1'b0;
		end else if (!below && !sync_q.below_backup) begin
			backup_q <= 1'b0;
		end else if (below && sync_q.below_backup) begin
			backup_q <= 1'b1;
		end
	end

	// Flag outputs that follow the comparators directly.
	// The supply flags are one register behind the synchroniser; battery_active is one register behind the switch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			battery_active <= 1'b0;
			supply_low_flag <= 1'b0;
			powerfail_flag <= 1'b0;
		end else begin
			battery_active <= backup_q;
			supply_low_flag <= ~below;
			powerfail_flag <= ~sync_q.sense_below_ref;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Chip-enable gate; a short hold keeps an access running into reset.
	// The hold is loaded only when the supply drops with the input low, and
	// any high input cancels it, so a finished access is never stretched.
	always_comb begin
		ce_tmr_d = ce_tmr_q;
		if (ce_in) begin
			ce_tmr_d = '0;
		end else if (below_rise) begin
			ce_tmr_d = CE_HOLD_CYCLES;
		end else if (ce_tmr_q != '0) begin
			ce_tmr_d = ce_tmr_q - 11'd1;
		end
	end

	// The gate passes a low input only while supply is good or held.
	wire ce_hold = (ce_tmr_d != '0);
	wire gated_d = ce_in | (below & ~ce_hold);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_tmr_q <= '0;
			chip_enable_gated <= 1'b1;
		end else begin
			ce_tmr_q <= ce_tmr_d;
			chip_enable_gated <= gated_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode: one wait state, answer registered.
	// The answer is built at the first access edge and stands one cycle;
	// a write takes effect only at the edge where the master sees pready.
	wire access = psel & penable;
	wire ack = access & ~pready;
	wire done = access & pready;
	wire hit_status = (paddr == ADDR_STATUS);
	wire hit_ctrl = (paddr == ADDR_CTRL);
	wire hit_timer = (paddr == ADDR_TIMER);
	wire hit = hit_status | hit_ctrl | hit_timer;
	wire ctrl_write = done & pwrite & hit_ctrl;

	// Read data selection; unmapped and status bits above read zero.
	// Status shows synchronised levels, so it lags the pins by two cycles.
	wire [31:0] status_word = (32'(below) << ST_BELOW_THR_BIT) |
		(32'(sync_q.below_backup) << ST_BELOW_BAK_BIT) |
		(32'(sync_q.sense_below_ref) << ST_SENSE_LOW_BIT) |
		(32'(backup_q) << ST_BATT_BIT) |
		(32'(reset_n) << ST_RESET_BIT) |
		(32'(timeout_flag) << ST_TIMEOUT_BIT) |
		(32'(first_q) << ST_FIRST_BIT) |
		(32'(wd_on) << ST_WD_ON_BIT) |
		(32'(ext_mode) << ST_EXT_BIT) |
		(32'(state_q) << ST_STATE_LSB);
	wire [31:0] ctrl_word = 32'(ctrl_wd_en_q) << CTRL_WD_EN_BIT;
	wire [31:0] timer_word = 32'(tmr_q);

	always_comb begin
		rdata = '0;
		if (hit_status) begin
			rdata = status_word;
		end else if (hit_ctrl) begin
			rdata = ctrl_word;
		end else if (hit_timer) begin
			rdata = timer_word;
		end
	end

	// Bus answer registers; a write lands on the completing edge.
	// Read data is zero outside the answer cycle, so a stale word is never
	// left standing on the bus.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= ack;
			prdata <= (ack & ~pwrite) ? rdata : 32'h0;
			pslverr <= ack & ~hit;
		end
	end

	// Control register.
	// Clearing the enable stops the watchdog and holds its flag high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_wd_en_q <= CTRL_WD_EN_RESET;
		end else if (ctrl_write) begin
			ctrl_wd_en_q <= pwdata[CTRL_WD_EN_BIT];
		end
	end

endmodule : supply_supervisor_watchdog
`default_nettype wire

// [verif/kick_host.sv]
// Host processor model that drives the three-level kick input.
`timescale 1ns/10ps
`default_nettype none
module kick_host (
	input wire logic pclk,
	input wire logic [1:0] mode,
	input wire logic [15:0] gap,
	output logic kick_high,
	output logic kick_low
);
	logic [15:0] cnt_q = '0;
	logic lvl_q = 1'b0;
	// Mode 0 floats the pin, 1 holds it, 2 toggles it every gap+1 cycles.
	always @(posedge pclk) begin
		cnt_q <= (cnt_q >= gap) ? '0 : cnt_q + 16'd1;
		if (mode == 2'd2 && cnt_q >= gap) lvl_q <= !lvl_q;
	end
	assign kick_high = mode != 2'd0 && lvl_q;
	assign kick_low = mode != 2'd0 && !lvl_q;
endmodule : kick_host
`default_nettype wire

// [verif/supervisor_checker.sv]
// Concurrent checks on the supply supervisor outputs.
`timescale 1ns/10ps
`default_nettype none
module supervisor_checker #(
	parameter int TICK_LEN = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire supervisor_pkg::pins_t pins,
	input wire logic reset_n,
	input wire logic reset_hi,
	input wire logic supply_low_flag,
	input wire logic powerfail_flag,
	input wire logic battery_active,
	input wire logic timeout_flag,
	input wire logic chip_enable_gated
);
	import supervisor_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	int low_cnt_q;
	// Counts the cycles the reset output has been held low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_q <= 0;
		end else begin
			low_cnt_q <= reset_n ? 0 : low_cnt_q + 1;
		end
	end
	sequence supply_bad;
		pins.below_threshold [*4];
	endsequence
	sequence supply_good;
		(!pins.below_threshold) [*4];
	endsequence
	sequence kick_mid;
		(!pins.kick_high && !pins.kick_low) [*4];
	endsequence
	sequence sense_low;
		pins.sense_below_ref [*4];
	endsequence
	sequence sense_good;
		(!pins.sense_below_ref) [*4];
	endsequence
	// The switch output sits one register behind the other flags.
	sequence on_backup;
		(pins.below_threshold && pins.below_backup) [*5];
	endsequence
	sequence on_main;
		(!pins.below_threshold && !pins.below_backup) [*5];
	endsequence
	sequence ce_high;
		pins.chip_enable_in [*4];
	endsequence
	sequence in_reset;
		!reset_n && timeout_flag;
	endsequence
	sequence wd_fire;
		$fell(timeout_flag);
	endsequence
	sequence int_reset_end;
		$rose(reset_n) && pins.timebase_select;
	endsequence
	sequence held_long;
		low_cnt_q >= (RESET_TICKS - 1) * TICK_LEN;
	endsequence
	AST_INVERSE: assert property (reset_hi == !reset_n)
		else $error("reset outputs not complementary");
	AST_LOW_LINE: assert property (supply_bad |-> !supply_low_flag)
		else $error("low-line flag high under threshold");
	AST_LOW_UP: assert property (supply_good |-> supply_low_flag)
		else $error("low-line flag low with supply good");
	AST_RESET_LOW: assert property (supply_bad |-> in_reset)
		else $error("reset or timeout flag wrong on low supply");
	AST_PFAIL: assert property (sense_low |-> !powerfail_flag)
		else $error("power-fail flag high with sense low");
	AST_PFAIL_OK: assert property (sense_good |-> powerfail_flag)
		else $error("power-fail flag low with sense good");
	AST_BACKUP: assert property (on_backup |-> battery_active)
		else $error("backup not selected");
	AST_MAIN: assert property (on_main |-> !battery_active)
		else $error("main supply not selected");
	AST_GATE: assert property (ce_high |-> chip_enable_gated)
		else $error("gated enable low with input high");
	AST_WD_RESET: assert property (wd_fire |-> $fell(reset_n))
		else $error("timeout flag fell without reset");
	AST_WD_OFF: assert property (kick_mid |-> !$fell(timeout_flag))
		else $error("watchdog fired with kick floating");
	AST_RESET_LEN: assert property (int_reset_end |-> held_long)
		else $error("reset pulse too short");
endmodule : supervisor_checker
bind supply_supervisor_watchdog supervisor_checker #(.TICK_LEN(TICK_LEN)) chk_i (
	.pclk, .presetn, .pins, .reset_n, .reset_hi, .supply_low_flag,
	.powerfail_flag, .battery_active, .timeout_flag, .chip_enable_gated);
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the supply supervisor.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import supervisor_pkg::*;
	localparam int TL = 10;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, reset_n, reset_hi, supply_low_flag, er;
	logic powerfail_flag, battery_active, timeout_flag, chip_enable_gated;
	logic bt = 1'b0, bb = 1'b0, sl = 1'b0, ts = 1'b1, tl = 1'b1, ce = 1'b1;
	logic kh, kl;
	logic [1:0] kmode = 2'd1;
	logic [15:0] kgap = 16'd200;
	logic [1:0] tdiv = '0;
	pins_t pins;
	int err_count = 0, checks_done = 0, now = 0, t0;
	assign pins = '{bt, bb, sl, kh, kl, ts, ts ? tl : tdiv[1], ce};
	// Clock, cycle count and a four-cycle external timebase.
	always #5 pclk = ~pclk;
	always @(posedge pclk) now <= now + 1;
	always @(posedge pclk) tdiv <= tdiv + 2'd1;
	supply_supervisor_watchdog #(.TICK_LEN(TL)) dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins,
		.reset_n, .reset_hi, .supply_low_flag, .powerfail_flag,
		.battery_active, .timeout_flag, .chip_enable_gated);
	kick_host host (.pclk, .mode(kmode), .gap(kgap), .kick_high(kh),
		.kick_low(kl));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		checks_done++;
		if (seen !== ex) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, ex, seen);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	task wait_on(input bit rst, input logic v, input int lim);
		int k;
		k = 0;
		while ((rst ? reset_n : timeout_flag) !== v && k < lim) begin
			@(posedge pclk);
			k++;
		end
	endtask : wait_on
	// Expected span with one kick gap of slack below.
	function automatic logic near(input int v, input int e);
		return v >= e - 220 && v <= e + 20;
	endfunction : near
	// Main sequence.
	initial begin
		void'($urandom(86));
		cyc(6);
		presetn <= 1'b1;
		t0 = now;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_rst", rd, 32'h1);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_wr", rd, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("st_reset", rd[ST_RESET_BIT], 0);
		apb(1'b0, 12'h00c, 32'h0);
		chk("slverr", er, 1);
		$display("test apb done");
		wait_on(1, 1, 2300);
		chk("rst_len", near(now - t0, RESET_TICKS * TL), 1);
		repeat (20) begin
			sl <= 1'($urandom);
			bb <= 1'($urandom);
			ce <= 1'($urandom);
			cyc(6);
			chk("pfail", powerfail_flag, !sl);
			chk("gate", chip_enable_gated, ce);
			chk("batt", battery_active, 0);
			chk("lowline", supply_low_flag, 1);
		end
		$display("test flags done");
		ce <= 1'b0;
		bb <= 1'b1;
		bt <= 1'b1;
		tl <= 1'b0;
		cyc(6);
		chk("rst_low", reset_n, 0);
		chk("low", supply_low_flag, 0);
		chk("battery_active", battery_active, 1);
		chk("ce_hold", chip_enable_gated, 0);
		cyc(CE_HOLD_CYCLES + 4);
		chk("ce_rel", chip_enable_gated, 1);
		bt <= 1'b0;
		bb <= 1'b0;
		cyc(6);
		chk("batt_off", battery_active, 0);
		chk("low_up", supply_low_flag, 1);
		t0 = now;
		wait_on(1, 1, 2300);
		chk("rst_len2", near(now - t0, RESET_TICKS * TL), 1);
		$display("test drop done");
		t0 = now;
		wait_on(0, 0, 17000);
		chk("wd_first", near(now - t0, WD_LONG_TICKS * TL), 1);
		chk("wd_rst", reset_n, 0);
		t0 = now;
		wait_on(1, 1, 2300);
		chk("wd_len", near(now - t0, RESET_TICKS * TL), 1);
		chk("wdo_held", timeout_flag, 0);
		kmode <= 2'd2;
		cyc(220);
		chk("wdo_clr", timeout_flag, 1);
		cyc(3000);
		chk("kicked", reset_n, 1);
		kmode <= 2'd1;
		t0 = now;
		wait_on(0, 0, 1300);
		chk("wd_short", near(now - t0, WD_SHORT_TICKS * TL), 1);
		wait_on(1, 1, 2300);
		$display("test watchdog done");
		kmode <= 2'd2;
		cyc(220);
		kmode <= 2'd0;
		cyc(17000);
		chk("wd_off", timeout_flag, 1);
		chk("wd_off_rst", reset_n, 1);
		$display("test float done");
		ts <= 1'b0;
		bt <= 1'b1;
		cyc(6);
		bt <= 1'b0;
		t0 = now;
		wait_on(1, 1, 9000);
		chk("ext_rst", near(now - t0, EXT_RESET_PERIODS * 4), 1);
		kmode <= 2'd2;
		cyc(220);
		kmode <= 2'd1;
		t0 = now;
		wait_on(0, 0, 5000);
		chk("ext_wd", near(now - t0, EXT_WD_PERIODS * 4), 1);
		$display("test external done");
		wrap_up();
	end
	// The tests need about 60000 cycles; give up at 100000.
	initial begin
		#1000000;
		err_count++;
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
